/* File: src/timer_pwm_regs.svh */
// register indices, field positions, reset values and timing counts of the dual timer pwm block
`ifndef TIMER_PWM_REGS_SVH
`define TIMER_PWM_REGS_SVH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define IDX_CONTROL_B 10'h091
`define IDX_MODE 10'h080
`define IDX_RUN 10'h081
`define IDX_FLAGS 10'h082
`define IDX_COUNT_FIRST 10'h083
`define IDX_COUNT_SECOND 10'h084
`define IDX_RELOAD_FIRST 10'h085
`define IDX_RELOAD_SECOND 10'h086
`define IDX_PIN_STATUS 10'h087

// ------------------------------------------------------------
// timer_pwm_control_b fields
// ------------------------------------------------------------
`define CTRL_PWM_EN_SECOND 7
`define CTRL_PWM_EN_FIRST 6
`define CTRL_PSC_SECOND_LSB 3
`define CTRL_PSC_FIRST_LSB 0
`define CTRL_RESET 8'h24

// ------------------------------------------------------------
// timer_mode_register fields, per timer nibble {gate, c/t, mode[1:0]}
// ------------------------------------------------------------
`define MODE_FIELD_LSB 0
`define MODE_CT_BIT 2
`define MODE_GATE_BIT 3
`define MODE_NIBBLE 4
`define MODE_RESET 8'h00

// ------------------------------------------------------------
// run register fields
// ------------------------------------------------------------
`define RUN_FIRST_BIT 0
`define RUN_SECOND_BIT 1
`define RUN_TPS_LSB 4
`define RUN_RESET 8'h00

// ------------------------------------------------------------
// counter constants
// ------------------------------------------------------------
`define COUNT_MAX 8'hff
`define COUNT_ZERO 8'h00

`endif

/* File: src/timer_pwm_pkg.sv */
// types shared by the dual timer pwm block
`default_nettype none
package timer_pwm_pkg;

  typedef enum logic [1:0] {
    PWM_LOG_PRESCALE,
    PWM_LIN_PRESCALE,
    PWM_FREQ_GEN,
    PWM_SPLIT
  } pwm_mode_e;

  // state of one 8-bit pwm counter channel
  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] hid;
    logic lvl;
    logic ovf;
  } pwm_s;

  typedef struct packed {
    logic sel;
    logic en;
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } apb_req_s;

endpackage
`default_nettype wire

/* File: src/timer_pwm_dual_channel.sv */
// two 8-bit timer pwm channels with apb register access
//
// The APB register port was chosen for this implementation.
`include "timer_pwm_regs.svh"
`default_nettype none

module timer_pwm_dual_channel
  import timer_pwm_pkg::*;
#(
  parameter int TPS_WIDTH = 4
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic external_gate_input_first_in,
  input wire logic external_gate_input_second_in,
  input wire logic first_timer_pin_in,
  input wire logic second_timer_pin_in,
  output logic first_timer_pin_out,
  output logic first_timer_pin_oe_out,
  output logic second_timer_pin_out,
  output logic second_timer_pin_oe_out,
  output logic overflow_flag_first_out,
  output logic overflow_flag_second_out,
  output logic baud_tick_out
);

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  apb_req_s req;
  assign req = '{sel: psel_in, en: penable_in, wr: pwrite_in, addr: paddr_in, wdata: pwdata_in};

  wire [9:0] idx = req.addr[11:2];
  wire hit_ctrl = (idx == `IDX_CONTROL_B);
  wire hit_mode = (idx == `IDX_MODE);
  wire hit_run = (idx == `IDX_RUN);
  wire hit_flags = (idx == `IDX_FLAGS);
  wire hit_cnt0 = (idx == `IDX_COUNT_FIRST);
  wire hit_cnt1 = (idx == `IDX_COUNT_SECOND);
  wire hit_rel0 = (idx == `IDX_RELOAD_FIRST);
  wire hit_rel1 = (idx == `IDX_RELOAD_SECOND);
  wire hit_pins = (idx == `IDX_PIN_STATUS);
  wire mapped = hit_ctrl | hit_mode | hit_run | hit_flags | hit_cnt0 | hit_cnt1 | hit_rel0 | hit_rel1 | hit_pins;
  wire access = req.sel & req.en & ce_in;
  wire wr_ok = access & req.wr & mapped;
  wire setup = req.sel & ~req.en & ce_in;

  // zero wait states; the clock enable stalls the bus too
  assign pready_out = access;
  assign pslverr_out = access & ~mapped;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] control_b;
  logic [7:0] timer_mode_register;
  logic [7:0] run_reg;
  logic [1:0] flags;
  logic [7:0] count_low [2];
  logic [7:0] count_high [2];
  logic [7:0] reload_low [2];
  logic [7:0] reload_high [2];
  logic [7:0] hid_hi [2];
  logic [7:0] hid_split;
  logic [1:0] pin_lvl;

  wire [1:0] pwm_enable = {control_b[`CTRL_PWM_EN_SECOND], control_b[`CTRL_PWM_EN_FIRST]};
  wire [2:0] log_prescale_first = control_b[`CTRL_PSC_FIRST_LSB +: 3];
  wire [2:0] log_prescale_second = control_b[`CTRL_PSC_SECOND_LSB +: 3];
  wire [1:0] run_bits = {run_reg[`RUN_SECOND_BIT], run_reg[`RUN_FIRST_BIT]};
  wire [TPS_WIDTH-1:0] global_timer_prescale = run_reg[`RUN_TPS_LSB +: TPS_WIDTH];

  // ------------------------------------------------------------
  // pin synchronisers and run/gate qualification
  // ------------------------------------------------------------
  wire [3:0] raw_in = {second_timer_pin_in, first_timer_pin_in,
                       external_gate_input_second_in, external_gate_input_first_in};
  logic [3:0] clean_in;
  logic [1:0] run_ok;
  logic [2:0] psc [2];

  assign psc[0] = log_prescale_first;
  assign psc[1] = log_prescale_second;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sync
      logic s1, s2, s3;
      always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          clean_in[g] <= 1'b0;
        end else if (ce_in) begin
          s1 <= raw_in[g];
          s2 <= s1;
          s3 <= s2;
          // a change counts only once two stages agree
          if (s2 == s3) begin
            clean_in[g] <= s3;
          end
        end
      end
    end
    for (g = 0; g < 2; g = g + 1) begin : g_run
      wire gate_bit = timer_mode_register[g*`MODE_NIBBLE + `MODE_GATE_BIT];
      assign run_ok[g] = run_bits[g] & (~gate_bit | clean_in[g]);
    end
  endgenerate

  wire [1:0] mode_first = timer_mode_register[`MODE_FIELD_LSB +: 2];
  wire [1:0] mode_second = timer_mode_register[`MODE_NIBBLE + `MODE_FIELD_LSB +: 2];
  pwm_mode_e sub_mode [2];
  assign sub_mode[0] = pwm_mode_e'(mode_first);
  assign sub_mode[1] = pwm_mode_e'(mode_second);
  wire split = pwm_enable[0] & (sub_mode[0] == PWM_SPLIT);

  // ------------------------------------------------------------
  // global prescaler
  // ------------------------------------------------------------
  logic [TPS_WIDTH-1:0] tps_cnt;
  wire tick = (tps_cnt == global_timer_prescale);

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tps_cnt <= '0;
    end else if (ce_in) begin
      tps_cnt <= tick ? '0 : tps_cnt + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // one pwm counter step
  // ------------------------------------------------------------
  function automatic pwm_s pwm_step(input logic [7:0] cnt, input logic [7:0] hid,
                                    input logic [7:0] duty, input logic lvl);
    pwm_s r;
    r.cnt = cnt + 8'h01;
    r.hid = hid;
    r.lvl = lvl;
    r.ovf = 1'b0;
    if (r.cnt == `COUNT_ZERO) begin
      r.hid = duty;
      r.lvl = (duty != `COUNT_ZERO);
      r.ovf = 1'b1;
    end else if (r.cnt == hid) begin
      r.lvl = 1'b0;
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // counting
  // ------------------------------------------------------------
  logic [7:0] next_low [2];
  logic [7:0] next_high [2];
  logic [7:0] next_hid_hi [2];
  logic [7:0] next_hid_split;
  logic [1:0] next_lvl;
  logic [1:0] ovf_set;
  logic baud_ovf;

  always_comb begin
    pwm_s st;
    logic [7:0] mask;
    st = '0;
    mask = '0;
    next_hid_split = hid_split;
    next_lvl = pin_lvl;
    ovf_set = 2'b00;
    baud_ovf = 1'b0;
    for (int i = 0; i < 2; i++) begin
      next_low[i] = count_low[i];
      next_high[i] = count_high[i];
      next_hid_hi[i] = hid_hi[i];
      // second timer in sub-mode 3 simply holds, as if run were clear
      if (pwm_enable[i] && run_ok[i] && tick) begin
        case (sub_mode[i])
          PWM_LOG_PRESCALE: begin
            mask = 8'((9'h002 << psc[i]) - 9'h001);
            next_low[i] = (count_low[i] + 8'h01) & mask;
            if ((count_low[i] & mask) == mask) begin
              st = pwm_step(count_high[i], hid_hi[i], reload_high[i], pin_lvl[i]);
              next_high[i] = st.cnt;
              next_hid_hi[i] = st.hid;
              next_lvl[i] = st.lvl;
              ovf_set[i] = st.ovf;
            end
          end
          PWM_LIN_PRESCALE: begin
            if (count_low[i] == `COUNT_MAX) begin
              next_low[i] = reload_low[i];
              st = pwm_step(count_high[i], hid_hi[i], reload_high[i], pin_lvl[i]);
              next_high[i] = st.cnt;
              next_hid_hi[i] = st.hid;
              next_lvl[i] = st.lvl;
              ovf_set[i] = st.ovf;
            end else begin
              next_low[i] = count_low[i] + 8'h01;
            end
          end
          PWM_FREQ_GEN: begin
            // reload bytes untouched here, free for software storage
            if (count_low[i] == `COUNT_MAX) begin
              next_low[i] = count_high[i];
              next_lvl[i] = ~pin_lvl[i];
              ovf_set[i] = 1'b1;
            end else begin
              next_low[i] = count_low[i] + 8'h01;
            end
          end
          PWM_SPLIT: begin
            if (i == 0) begin // index 1 parks here untouched
              st = pwm_step(count_low[0], hid_split, reload_low[0], pin_lvl[0]);
              next_low[0] = st.cnt;
              next_hid_split = st.hid;
              next_lvl[0] = st.lvl;
              ovf_set[0] = st.ovf;
            end
          end
          default: begin
            next_low[i] = count_low[i];
          end
        endcase
      end
    end
    // second timer overflow feeds the baud rate even while first timer is split
    if (pwm_enable[1] && (sub_mode[1] != PWM_SPLIT)) begin
      baud_ovf = ovf_set[1];
    end
    // split high channel: pure timer on second timer's run and enable, no gate
    if (split) begin
      ovf_set[1] = 1'b0;
      if (pwm_enable[1] && run_bits[1] && tick) begin
        st = pwm_step(count_high[0], hid_hi[0], reload_high[0], pin_lvl[1]);
        next_high[0] = st.cnt;
        next_hid_hi[0] = st.hid;
        next_lvl[1] = st.lvl;
        ovf_set[1] = st.ovf;
      end
    end
  end

  // ------------------------------------------------------------
  // register and counter update
  // ------------------------------------------------------------
  wire [1:0] hit_cnt = {hit_cnt1, hit_cnt0};
  wire [1:0] hit_rel = {hit_rel1, hit_rel0};

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      control_b <= `CTRL_RESET;
      timer_mode_register <= `MODE_RESET;
      run_reg <= `RUN_RESET;
      hid_split <= '0;
      pin_lvl <= '0;
    end else if (ce_in) begin
      if (wr_ok && hit_ctrl) begin
        control_b <= req.wdata[7:0];
      end
      if (wr_ok && hit_mode) begin
        timer_mode_register <= req.wdata[7:0];
      end
      if (wr_ok && hit_run) begin
        run_reg <= req.wdata[7:0];
      end
      hid_split <= next_hid_split;
      pin_lvl <= next_lvl;
    end
  end

  // flags: hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flags <= '0;
    end else if (ce_in) begin
      flags <= (flags & ~((wr_ok && hit_flags) ? req.wdata[1:0] : 2'b00)) | ovf_set;
    end
  end

  // software writes to the count take priority over counting
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_cnt
      always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          count_low[g] <= '0;
          count_high[g] <= '0;
          reload_low[g] <= '0;
          reload_high[g] <= '0;
          hid_hi[g] <= '0;
        end else if (ce_in) begin
          count_low[g] <= (wr_ok && hit_cnt[g]) ? req.wdata[7:0] : next_low[g];
          count_high[g] <= (wr_ok && hit_cnt[g]) ? req.wdata[15:8] : next_high[g];
          if (wr_ok && hit_rel[g]) begin
            reload_low[g] <= req.wdata[7:0];
            reload_high[g] <= req.wdata[15:8];
          end
          hid_hi[g] <= next_hid_hi[g];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // read data, captured in the setup cycle
  // ------------------------------------------------------------
  wire [31:0] rd_mux =
    hit_ctrl ? {24'h000000, control_b} :
    hit_mode ? {24'h000000, timer_mode_register} :
    hit_run ? {24'h000000, run_reg} :
    hit_flags ? {30'h00000000, flags} :
    hit_cnt0 ? {16'h0000, count_high[0], count_low[0]} :
    hit_cnt1 ? {16'h0000, count_high[1], count_low[1]} :
    hit_rel0 ? {16'h0000, reload_high[0], reload_low[0]} :
    hit_rel1 ? {16'h0000, reload_high[1], reload_low[1]} :
    hit_pins ? {28'h0000000, clean_in[3:2], pin_lvl} :
    32'h00000000;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prdata_out <= '0;
      baud_tick_out <= 1'b0;
    end else if (ce_in) begin
      if (setup && !req.wr) begin
        prdata_out <= rd_mux;
      end
      baud_tick_out <= baud_ovf;
    end
  end

  // ------------------------------------------------------------
  // pins
  // ------------------------------------------------------------
  // counter-select must be zero under pwm; the pin is driven regardless
  assign first_timer_pin_out = pin_lvl[0];
  assign first_timer_pin_oe_out = pwm_enable[0];
  assign second_timer_pin_out = pin_lvl[1];
  assign second_timer_pin_oe_out = pwm_enable[1] | (split & pwm_enable[1]);
  assign overflow_flag_first_out = flags[0];
  assign overflow_flag_second_out = flags[1];

endmodule // timer_pwm_dual_channel
`default_nettype wire

/* File: tb/timer_pwm_asserts.sv */
// concurrent checks on the ports of the dual timer pwm block
`include "timer_pwm_regs.svh"
`default_nettype none
module timer_pwm_asserts (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic external_gate_input_first_in,
  input wire logic first_timer_pin_out,
  input wire logic first_timer_pin_oe_out,
  input wire logic second_timer_pin_out,
  input wire logic second_timer_pin_oe_out,
  input wire logic overflow_flag_first_out,
  input wire logic overflow_flag_second_out,
  input wire logic baud_tick_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  // ------------------------------------------------------------
  // shadow of the bus writes and of the first gate input
  // ------------------------------------------------------------
  logic [7:0] ctrl;
  logic gate_on;
  logic [2:0] glow;
  wire logic [9:0] idx = paddr_in[11:2];
  wire logic acc = psel_in && penable_in;
  wire logic wr = acc && ce_in && pwrite_in;
  wire logic mapped = idx == `IDX_CONTROL_B || (idx >= `IDX_MODE && idx <= `IDX_PIN_STATUS);
  wire logic fwr = wr && idx == `IDX_FLAGS;
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl <= `CTRL_RESET;
      gate_on <= 1'b0;
      glow <= 3'h0;
    end else begin
      if (wr && idx == `IDX_CONTROL_B) ctrl <= pwdata_in[7:0];
      if (wr && idx == `IDX_MODE) gate_on <= pwdata_in[`MODE_GATE_BIT];
      // saturates: only "long enough low" matters, past the synchroniser
      glow <= external_gate_input_first_in ? 3'h0 : (glow == 3'h7 ? glow : glow + 3'h1);
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  oe_first_a:
    assert property (first_timer_pin_oe_out == ctrl[`CTRL_PWM_EN_FIRST]) else $error("first enable wrong");
  oe_second_a:
    assert property (second_timer_pin_oe_out == ctrl[`CTRL_PWM_EN_SECOND]) else $error("second enable wrong");
  ready_now_a:
    assert property (pready_out == (acc && ce_in)) else $error("pready wrong");
  // a frozen block answers nothing, so the error flag only counts with the enable high
  slverr_map_a:
    assert property (acc && ce_in |-> pslverr_out == !mapped) else $error("pslverr wrong");
  unmapped_zero_a:
    assert property (acc && !pwrite_in && !mapped |-> prdata_out == 32'h0) else $error("unmapped read not zero");
  flag_first_a:
    assert property (overflow_flag_first_out && !(fwr && pwdata_in[0]) |=> overflow_flag_first_out)
    else $error("first flag lost");
  flag_second_a:
    assert property (overflow_flag_second_out && !(fwr && pwdata_in[1]) |=> overflow_flag_second_out)
    else $error("second flag lost");
  freeze_a:
    assert property (!ce_in |=> $stable({first_timer_pin_out, second_timer_pin_out, overflow_flag_first_out}))
    else $error("state moved while frozen");
  gate_halt_a:
    assert property (gate_on && glow == 3'h7 |=> $stable(first_timer_pin_out)) else $error("gate did not halt");
  off_hold_a:
    assert property (!first_timer_pin_oe_out |=> $stable(first_timer_pin_out)) else $error("disabled pin moved");
  cover property ($rose(first_timer_pin_out));
  cover property (baud_tick_out);
  cover property (acc && pslverr_out);
endmodule // timer_pwm_asserts
bind timer_pwm_dual_channel timer_pwm_asserts chk (.sys_clk_in, .rstn_in, .ce_in, .psel_in, .penable_in,
  .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .external_gate_input_first_in,
  .first_timer_pin_out, .first_timer_pin_oe_out, .second_timer_pin_out, .second_timer_pin_oe_out,
  .overflow_flag_first_out, .overflow_flag_second_out, .baud_tick_out);
`default_nettype wire

/* File: tb/pwm_load_model.sv */
// load on one pwm pin: resolves the wire, counts high cycles and rising edges
`default_nettype none
module pwm_load_model (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic clr_in,
  input wire logic pin_level_in,
  input wire logic pin_oe_in,
  output logic pin_wire_out,
  output logic [15:0] high_cnt_out,
  output logic [15:0] rise_cnt_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev;
  // pulled up when released, so a missing enable never reads as a driven low
  assign pin_wire_out = pin_oe_in ? pin_level_in : 1'b1;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prev <= 1'b1;
      high_cnt_out <= 16'h0000;
      rise_cnt_out <= 16'h0000;
    end else begin
      prev <= pin_wire_out;
      high_cnt_out <= clr_in ? 16'h0000 : high_cnt_out + {15'h0000, pin_wire_out};
      rise_cnt_out <= clr_in ? 16'h0000 : rise_cnt_out + {15'h0000, pin_wire_out && !prev};
    end
  end
endmodule // pwm_load_model
`default_nettype wire

/* File: tb/timer_pwm_dual_channel_test.sv */
// self-checking bench for the dual timer pwm block
`include "timer_pwm_regs.svh"
`default_nettype none
module timer_pwm_dual_channel_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic g0 = 1'b1;
  logic g1 = 1'b1;
  logic clr = 1'b0;
  logic [31:0] q;
  logic e;
  logic [15:0] bcnt = 16'h0000;
  wire logic [31:0] prd;
  wire logic rdy, err, p0, oe0, p1, oe1, w0, w1, f0, f1, bt;
  wire logic [15:0] h0, r0, h1, r1;
  int num_errors = 0;
  int checked = 0;
  typedef struct packed {
    logic [7:0] mode, ctrl, run;
    logic [15:0] rel, cnt, high, rise;
  } row_s;
  row_s rows [5] = '{
    '{8'h01, 8'h64, 8'h01, 16'h02ff, 16'h0000, 16'h0008, 16'h0004},
    '{8'h01, 8'h64, 8'h11, 16'h02ff, 16'h0000, 16'h0008, 16'h0002},
    '{8'h00, 8'h40, 8'h01, 16'h0200, 16'h0000, 16'h0008, 16'h0002},
    '{8'h01, 8'h64, 8'h01, 16'h00ff, 16'h0000, 16'h0000, 16'h0000},
    '{8'h02, 8'h64, 8'h01, 16'h1234, 16'hfcfc, 16'h0200, 16'h0080}};
  always #50 clk = ~clk;
  always @(posedge clk) bcnt <= clr ? 16'h0000 : bcnt + {15'h0000, bt};
  timer_pwm_dual_channel DUT (.sys_clk_in(clk), .rstn_in(rstn), .ce_in(ce), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(padr), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(rdy), .pslverr_out(err), .external_gate_input_first_in(g0),
    .external_gate_input_second_in(g1), .first_timer_pin_in(w0), .second_timer_pin_in(w1),
    .first_timer_pin_out(p0), .first_timer_pin_oe_out(oe0), .second_timer_pin_out(p1),
    .second_timer_pin_oe_out(oe1), .overflow_flag_first_out(f0), .overflow_flag_second_out(f1),
    .baud_tick_out(bt));
  pwm_load_model load0 (.clk_in(clk), .rstn_in(rstn), .clr_in(clr), .pin_level_in(p0), .pin_oe_in(oe0),
    .pin_wire_out(w0), .high_cnt_out(h0), .rise_cnt_out(r0));
  pwm_load_model load1 (.clk_in(clk), .rstn_in(rstn), .clr_in(clr), .pin_level_in(p1), .pin_oe_in(oe1),
    .pin_wire_out(w1), .high_cnt_out(h1), .rise_cnt_out(r1));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // no cycle limit here: a stalled slave is left to the watchdog
  task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= {i, 2'b00};
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    q = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    apb(1'b1, i, d);
  endtask
  task automatic rd(input logic [9:0] i, input logic [31:0] exp);
    apb(1'b0, i, 32'h0);
    chk(q, exp);
  endtask
  task automatic meas(input int n);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    // one extra edge so the last sample has landed; inputs stay on the edge
    repeat (n + 1) @(posedge clk);
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  // about three times the expected run, so a stalled bus ends it
  initial begin
    #6000000;
    num_errors++;
    end_sim;
  end
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      wr(`IDX_MODE, {24'h0, rows[i].mode});
      wr(`IDX_RELOAD_FIRST, {16'h0, rows[i].rel});
      wr(`IDX_COUNT_FIRST, {16'h0, rows[i].cnt});
      wr(`IDX_RUN, {24'h0, rows[i].run});
      wr(`IDX_CONTROL_B, {24'h0, rows[i].ctrl});
      repeat (1100) @(posedge clk);
      meas(1024);
      chk({16'h0, h0}, {16'h0, rows[i].high});
      chk({16'h0, r0}, {16'h0, rows[i].rise});
    end
    rd(`IDX_RELOAD_FIRST, 32'h1234);
    rd(`IDX_FLAGS, 32'h1);
    wr(`IDX_RUN, 32'h0);
    wr(`IDX_FLAGS, 32'h3);
    rd(`IDX_FLAGS, 32'h0);
    apb(1'b1, 10'h088, 32'hff);
    chk({31'h0, e}, 32'h1);
    rd(`IDX_CONTROL_B, 32'h64);
    rd(10'h090, 32'h0);
    chk({31'h0, e}, 32'h1);
    // gate held low before the timer runs, then released
    g0 <= 1'b0;
    wr(`IDX_MODE, 32'h09);
    wr(`IDX_RELOAD_FIRST, 32'h02ff);
    wr(`IDX_RUN, 32'h01);
    meas(1024);
    chk({16'h0, r0}, 32'h0);
    g0 <= 1'b1;
    repeat (1100) @(posedge clk);
    meas(1024);
    chk({16'h0, r0}, 32'h4);
    // split mode: second pin from the high byte, second timer parked
    wr(`IDX_MODE, 32'h33);
    wr(`IDX_RELOAD_FIRST, 32'h0402);
    wr(`IDX_COUNT_SECOND, 32'h0055);
    wr(`IDX_CONTROL_B, 32'he4);
    wr(`IDX_RUN, 32'h03);
    repeat (600) @(posedge clk);
    meas(1024);
    chk({16'h0, h0}, 32'h8);
    chk({16'h0, r0}, 32'h4);
    chk({16'h0, h1}, 32'h10);
    chk({16'h0, r1}, 32'h4);
    chk({16'h0, bcnt}, 32'h0);
    rd(`IDX_COUNT_SECOND, 32'h0055);
    wr(`IDX_RUN, 32'h01);
    meas(512);
    chk({16'h0, r1}, 32'h0);
    chk({16'h0, r0}, 32'h2);
    wr(`IDX_MODE, 32'h23);
    wr(`IDX_RUN, 32'h03);
    repeat (600) @(posedge clk);
    meas(1024);
    chk({16'h0, bcnt}, 32'h4);
    ce <= 1'b0;
    meas(300);
    chk({16'h0, r0 | r1}, 32'h0);
    ce <= 1'b1;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd(`IDX_CONTROL_B, 32'h24);
    chk({30'h0, oe1, oe0}, 32'h0);
    rd(`IDX_MODE, 32'h0);
    rd(`IDX_RUN, 32'h0);
    end_sim;
  end
endmodule // timer_pwm_dual_channel_test
`default_nettype wire
